/* hw/bwsfe_consts.svh */
/*
 Offsets, field positions, codes and counts of the configuration front end.
 Assumes inclusion by bare name from every file that needs a constant.
*/
`ifndef BWSFE_CONSTS_SVH
`define BWSFE_CONSTS_SVH
`define BWSFE_SYNC_WORD 32'haa995566
`define BWSFE_PAD_WORD 32'hffffffff
`define BWSFE_DET_WORD1 32'h000000bb
`define BWSFE_DET_WORD2 32'h11220044
`define BWSFE_DET_FIRST 8'hbb
`define BWSFE_DET_X8 8'h11
`define BWSFE_DET_X16 8'h22
`define BWSFE_DET_X32 8'h44
`define BWSFE_PAD_COUNT 16
`define BWSFE_GAP_COUNT 2
`define BWSFE_TYPE_HI 31
`define BWSFE_TYPE_LO 29
`define BWSFE_OP_HI 28
`define BWSFE_OP_LO 27
`define BWSFE_REG_HI 17
`define BWSFE_REG_LO 13
`define BWSFE_CNT1_HI 10
`define BWSFE_CNT2_HI 26
`define BWSFE_CMD_HI 4
`define BWSFE_TYPE1 3'h1
`define BWSFE_TYPE2 3'h2
`define BWSFE_OP_WRITE 2'h2
`define BWSFE_REG_FAR 5'h01
`define BWSFE_REG_FDRI 5'h02
`define BWSFE_REG_CMD 5'h04
`define BWSFE_REG_WARM_BOOT_START_ADDR 5'h10
`define BWSFE_REG_TIMER 5'h11
`define BWSFE_CMD_NULL 5'h00
`define BWSFE_CMD_CRC_CLEAR 5'h07
`define BWSFE_CMD_INTERNAL_REPROGRAM_CMD 5'h0f
`define BWSFE_CRC_POLY 32'h1edc6f41
`define BWSFE_FRAME_WORDS 16
`endif

/* hw/bwsfe_dev.sv */
/*
 Device end: parallel width detection, sync word hunt, word assembly, a small
 word buffer and the packet header decoder with its sample registers.
 Assumes the master shares i_mclk; serial modes deliver whole words per beat.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bwsfe_consts.svh"
module bwsfe_dev
    import bwsfe_pkg::*;
#(
    parameter int BUF_DEPTH = 2,
    parameter int FRAME_WORDS = `BWSFE_FRAME_WORDS,
    parameter logic [4:0] INTERNAL_REPROGRAM_CMD_CODE = `BWSFE_CMD_INTERNAL_REPROGRAM_CMD
)(
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_program_pulse,
    input wire logic i_jtag_reprogram_instr,
    input wire logic i_serial_mode,
    bwsfe_link_if.dev link,
    output logic [1:0] o_width,
    output logic o_width_locked,
    output logic o_synced,
    output logic [31:0] o_pkt_data,
    output logic [4:0] o_pkt_reg,
    output logic o_pkt_valid,
    input wire logic i_pkt_ready,
    output logic [31:0] o_timer,
    output logic [31:0] o_warm_boot_start_addr,
    output logic [31:0] o_frame_address_reg,
    output logic o_crc_clear_cmd,
    output logic o_internal_reprogram_cmd,
    output logic [31:0] o_crc,
    output logic o_frame_done,
    output logic o_partial_frame
);
    localparam int PW = $clog2(BUF_DEPTH);
    localparam int FW = $clog2(FRAME_WORDS + 1);

    if (BUF_DEPTH < 2 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0 || FRAME_WORDS < 1)
    begin : g_bad_param
        $error("BUF_DEPTH must be a power of two >= 2 and FRAME_WORDS >= 1");
    end
    if (INTERNAL_REPROGRAM_CMD_CODE == `BWSFE_CMD_NULL || INTERNAL_REPROGRAM_CMD_CODE == `BWSFE_CMD_CRC_CLEAR)
    begin : g_bad_code
        $error("INTERNAL_REPROGRAM_CMD_CODE must differ from the null and CRC clear codes");
    end

    function automatic logic [31:0] shift_in(input logic [31:0] acc, input logic [31:0] d,
                                             input bwsfe_width_t w);
        case (w)
            BWSFE_W8: shift_in = {acc[23:0], d[7:0]};
            BWSFE_W16: shift_in = {acc[15:0], d[15:0]};
            default: shift_in = d;
        endcase
    endfunction

    function automatic logic is_last(input logic [1:0] cnt, input bwsfe_width_t w);
        case (w)
            BWSFE_W8: is_last = cnt == 2'h3;
            BWSFE_W16: is_last = cnt[0];
            default: is_last = 1'b1;
        endcase
    endfunction

    function automatic logic [31:0] crc_step(input logic [31:0] crc, input logic [31:0] d);
        logic [31:0] c;
        c = crc;
        for (int i = 31; i >= 0; i--)
            c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? `BWSFE_CRC_POLY : 32'h0);
        crc_step = c;
    endfunction

    bwsfe_link_st_t st_q, st_d;
    bwsfe_width_t width_q, width_d;
    bwsfe_dec_st_t dst_q;
    logic [31:0] acc_q, acc_next, rd_word, crc_q, timer_q, warm_boot_start_addr_q, far_q, pkt_data_q;
    logic [31:0] mem_q [BUF_DEPTH];
    logic [1:0] cnt_q;
    logic [7:0] low_byte;
    logic [PW-1:0] wp_q, rp_q;
    logic [PW:0] fill_q;
    logic [FW-1:0] frame_cnt_q;
    logic [26:0] left_q;
    logic [4:0] reg_q, pkt_reg_q, cmd_code;
    logic clr, beat, last_beat, sync_hit, word_push, buf_wr_rdy, rd_vld, pop;
    logic hdr_pop, pay_pop, is_write1, is_type2, hdr_act, pay_last, cmd_wr, fdri_wr;
    logic frame_last, crc_clr, internal_reprogram_cmd_q, crc_clr_q, pkt_vld_q, frame_done_q, partial_q;

    // Link side: detection, sync hunt, word assembly
    assign clr = i_reset | i_program_pulse | i_jtag_reprogram_instr | internal_reprogram_cmd_q;
    assign low_byte = link.data[7:0];
    assign acc_next = shift_in(acc_q, link.data, width_q);
    assign sync_hit = acc_next == `BWSFE_SYNC_WORD;
    assign last_beat = is_last(cnt_q, width_q);
    assign link.ready = (st_q != BWSFE_RUN) || !last_beat || buf_wr_rdy;
    assign beat = link.valid && link.ready;
    assign word_push = beat && st_q == BWSFE_RUN && last_beat;

    always_comb
    begin
        st_d = st_q;
        width_d = width_q;
        case (st_q)
            BWSFE_HUNT:
            begin
                if (i_serial_mode)
                begin
                    st_d = BWSFE_SYNC;
                    width_d = BWSFE_W32;
                end
                else if (beat && low_byte == `BWSFE_DET_FIRST)
                    st_d = BWSFE_PAIR;
            end
            BWSFE_PAIR:
            begin
                if (beat)
                begin
                    st_d = BWSFE_SYNC;
                    case (low_byte)
                        `BWSFE_DET_X8: width_d = BWSFE_W8;
                        `BWSFE_DET_X16: width_d = BWSFE_W16;
                        `BWSFE_DET_X32: width_d = BWSFE_W32;
                        default: st_d = BWSFE_HUNT;
                    endcase
                end
            end
            BWSFE_SYNC: if (beat && sync_hit) st_d = BWSFE_RUN;
            BWSFE_RUN: st_d = st_q;
            default: st_d = BWSFE_HUNT;
        endcase
    end

    always_ff @(posedge i_mclk)
    begin
        if (clr)
        begin
            st_q <= BWSFE_HUNT;
            width_q <= BWSFE_W32;
            acc_q <= 32'h0;
            cnt_q <= 2'h0;
        end
        else
        begin
            st_q <= st_d;
            width_q <= width_d;
            if (beat)
                acc_q <= acc_next;
            if (st_q != BWSFE_RUN)
                cnt_q <= 2'h0;
            else if (beat)
                cnt_q <= last_beat ? 2'h0 : cnt_q + 2'h1;
        end
    end

    // Word buffer; a full buffer stalls the link on a word's last beat
    assign buf_wr_rdy = fill_q != (PW + 1)'(BUF_DEPTH);
    assign rd_vld = fill_q != '0;
    assign rd_word = mem_q[rp_q];

    always_ff @(posedge i_mclk)
    begin
        if (clr)
        begin
            wp_q <= '0;
            rp_q <= '0;
            fill_q <= '0;
        end
        else
        begin
            if (word_push)
            begin
                mem_q[wp_q] <= acc_next;
                wp_q <= wp_q + PW'(1);
            end
            if (pop)
                rp_q <= rp_q + PW'(1);
            fill_q <= fill_q + (PW + 1)'(word_push) - (PW + 1)'(pop);
        end
    end

    // Packet decoder
    assign pop = rd_vld && (dst_q == BWSFE_HDR || !pkt_vld_q || i_pkt_ready);
    assign hdr_pop = pop && dst_q == BWSFE_HDR;
    assign pay_pop = pop && dst_q == BWSFE_PAY;
    assign is_write1 = rd_word[`BWSFE_TYPE_HI:`BWSFE_TYPE_LO] == `BWSFE_TYPE1 &&
                       rd_word[`BWSFE_OP_HI:`BWSFE_OP_LO] == `BWSFE_OP_WRITE;
    assign is_type2 = rd_word[`BWSFE_TYPE_HI:`BWSFE_TYPE_LO] == `BWSFE_TYPE2 &&
                      rd_word[`BWSFE_OP_HI:`BWSFE_OP_LO] == `BWSFE_OP_WRITE;
    assign hdr_act = hdr_pop && (is_write1 || is_type2);
    assign pay_last = left_q == 27'h1;
    assign cmd_code = rd_word[`BWSFE_CMD_HI:0];
    assign cmd_wr = pay_pop && reg_q == `BWSFE_REG_CMD;
    assign crc_clr = cmd_wr && cmd_code == `BWSFE_CMD_CRC_CLEAR;
    assign fdri_wr = pay_pop && reg_q == `BWSFE_REG_FDRI;
    assign frame_last = frame_cnt_q == FW'(FRAME_WORDS - 1);

    always_ff @(posedge i_mclk)
    begin
        if (clr)
        begin
            dst_q <= BWSFE_HDR;
            reg_q <= 5'h00;
            left_q <= 27'h0;
        end
        else if (hdr_act && is_write1)
        begin
            reg_q <= rd_word[`BWSFE_REG_HI:`BWSFE_REG_LO];
            left_q <= {16'h0, rd_word[`BWSFE_CNT1_HI:0]};
            if (rd_word[`BWSFE_CNT1_HI:0] != 11'h0)
                dst_q <= BWSFE_PAY;
        end
        else if (hdr_act && rd_word[`BWSFE_CNT2_HI:0] != 27'h0)
        begin
            left_q <= rd_word[`BWSFE_CNT2_HI:0];
            dst_q <= BWSFE_PAY;
        end
        else if (pay_pop)
        begin
            left_q <= left_q - 27'h1;
            if (pay_last)
                dst_q <= BWSFE_HDR;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            timer_q <= 32'h0;
            warm_boot_start_addr_q <= 32'h0;
            far_q <= 32'h0;
        end
        else if (pay_pop)
        begin
            case (reg_q)
                `BWSFE_REG_TIMER: timer_q <= rd_word;
                `BWSFE_REG_WARM_BOOT_START_ADDR: warm_boot_start_addr_q <= rd_word;
                `BWSFE_REG_FAR: far_q <= rd_word;
                default: far_q <= far_q;
            endcase
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            internal_reprogram_cmd_q <= 1'b0;
            crc_clr_q <= 1'b0;
        end
        else
        begin
            // The null code matches neither action and passes with no effect
            internal_reprogram_cmd_q <= cmd_wr && cmd_code == INTERNAL_REPROGRAM_CMD_CODE;
            crc_clr_q <= crc_clr;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (clr || crc_clr)
            crc_q <= 32'h0;
        else if (pop)
            crc_q <= crc_step(crc_q, rd_word);
    end

    always_ff @(posedge i_mclk)
    begin
        if (clr)
        begin
            frame_cnt_q <= '0;
            frame_done_q <= 1'b0;
            partial_q <= 1'b0;
        end
        else
        begin
            frame_done_q <= fdri_wr && frame_last;
            if (fdri_wr)
                frame_cnt_q <= frame_last ? '0 : frame_cnt_q + FW'(1);
            if (fdri_wr && pay_last && !frame_last)
                partial_q <= 1'b1;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (clr)
        begin
            pkt_vld_q <= 1'b0;
            pkt_data_q <= 32'h0;
            pkt_reg_q <= 5'h00;
        end
        else if (pay_pop)
        begin
            pkt_vld_q <= 1'b1;
            pkt_data_q <= rd_word;
            pkt_reg_q <= reg_q;
        end
        else if (i_pkt_ready)
            pkt_vld_q <= 1'b0;
    end

    assign o_width = width_q;
    assign o_width_locked = st_q == BWSFE_SYNC || st_q == BWSFE_RUN;
    assign o_synced = st_q == BWSFE_RUN;
    assign o_pkt_data = pkt_data_q;
    assign o_pkt_reg = pkt_reg_q;
    assign o_pkt_valid = pkt_vld_q;
    assign o_timer = timer_q;
    assign o_warm_boot_start_addr = warm_boot_start_addr_q;
    assign o_frame_address_reg = far_q;
    assign o_crc_clear_cmd = crc_clr_q;
    assign o_internal_reprogram_cmd = internal_reprogram_cmd_q;
    assign o_crc = crc_q;
    assign o_frame_done = frame_done_q;
    assign o_partial_frame = partial_q;
endmodule // bwsfe_dev
`default_nettype wire

/* hw/bwsfe_host.sv */
/*
 Master end: sends pad words, the width pattern, the sync word and then
 user words, split into beats of the chosen width, most significant first.
 Assumes i_width is valid in the cycle of i_start, when it is latched for the whole run.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bwsfe_consts.svh"
module bwsfe_host
    import bwsfe_pkg::*;
#(
    parameter int PAD_WORDS = `BWSFE_PAD_COUNT,
    parameter int GAP_WORDS = `BWSFE_GAP_COUNT
)(
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_start,
    input wire logic [1:0] i_width,
    input wire logic [31:0] i_word,
    input wire logic i_word_valid,
    output logic o_word_ready,
    output logic o_busy,
    bwsfe_link_if.host link
);
    if (PAD_WORDS < 1 || PAD_WORDS > 255 || GAP_WORDS < 1 || GAP_WORDS > 255)
    begin : g_bad_count
        $error("PAD_WORDS and GAP_WORDS must lie in 1..255");
    end

    bwsfe_host_st_t st_q, st_d;
    bwsfe_width_t width_q;
    logic [7:0] n_q;
    logic [31:0] sh_q, data_q, src_word, beat_word, sh_next;
    logic [2:0] left_q, beats;
    logic have_q, vld_q, src_vld, load, emit;

    assign src_word = (st_q == BWSFE_H_PAD || st_q == BWSFE_H_GAP) ? `BWSFE_PAD_WORD :
                      (st_q == BWSFE_H_DET) ? ((n_q == 8'h00) ? `BWSFE_DET_WORD1 : `BWSFE_DET_WORD2) :
                      (st_q == BWSFE_H_SYNC) ? `BWSFE_SYNC_WORD : i_word;
    assign src_vld = (st_q == BWSFE_H_DATA) ? i_word_valid : (st_q != BWSFE_H_IDLE);
    assign load = !have_q && src_vld;
    assign emit = have_q && (!vld_q || link.ready);
    assign o_word_ready = (st_q == BWSFE_H_DATA) && !have_q;
    assign o_busy = st_q != BWSFE_H_IDLE;
    assign beats = (width_q == BWSFE_W8) ? 3'h4 : (width_q == BWSFE_W16) ? 3'h2 : 3'h1;
    assign beat_word = (width_q == BWSFE_W8) ? {24'h0, sh_q[31:24]} :
                       (width_q == BWSFE_W16) ? {16'h0, sh_q[31:16]} : sh_q;
    assign sh_next = (width_q == BWSFE_W8) ? {sh_q[23:0], 8'h0} : {sh_q[15:0], 16'h0};
    assign link.data = data_q;
    assign link.valid = vld_q;

    always_comb
    begin
        st_d = st_q;
        case (st_q)
            BWSFE_H_IDLE: if (i_start) st_d = BWSFE_H_PAD;
            BWSFE_H_PAD: if (load && n_q == 8'(PAD_WORDS - 1)) st_d = BWSFE_H_DET;
            BWSFE_H_DET: if (load && n_q == 8'h01) st_d = BWSFE_H_GAP;
            BWSFE_H_GAP: if (load && n_q == 8'(GAP_WORDS - 1)) st_d = BWSFE_H_SYNC;
            BWSFE_H_SYNC: if (load) st_d = BWSFE_H_DATA;
            BWSFE_H_DATA: st_d = st_q;
            default: st_d = BWSFE_H_IDLE;
        endcase
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            st_q <= BWSFE_H_IDLE;
            width_q <= BWSFE_W32;
            n_q <= 8'h00;
        end
        else
        begin
            st_q <= st_d;
            if (st_q == BWSFE_H_IDLE && i_start)
                width_q <= bwsfe_width_t'(i_width);
            if (st_d != st_q)
                n_q <= 8'h00;
            else if (load)
                n_q <= n_q + 8'h01;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            have_q <= 1'b0;
            vld_q <= 1'b0;
            data_q <= 32'h0;
            sh_q <= 32'h0;
            left_q <= 3'h0;
        end
        else
        begin
            if (load)
            begin
                sh_q <= src_word;
                left_q <= beats;
                have_q <= 1'b1;
            end
            else if (emit)
            begin
                data_q <= beat_word;
                sh_q <= sh_next;
                left_q <= left_q - 3'h1;
                have_q <= left_q != 3'h1;
            end
            if (emit)
                vld_q <= 1'b1;
            else if (link.ready)
                vld_q <= 1'b0;
        end
    end
endmodule // bwsfe_host
`default_nettype wire

/* hw/bwsfe_link_if.sv */
/*
 Configuration data port between the external master and the device.
 Assumes both ends run on the same clock; lanes above the width are unused.
*/
`timescale 1ns/1ps
`default_nettype none
interface bwsfe_link_if;
    logic [31:0] data;
    logic valid;
    logic ready;
    modport dev (input data, input valid, output ready);
    modport host (output data, output valid, input ready);
endinterface
`default_nettype wire

/* hw/bwsfe_pkg.sv */
/*
 Types of the configuration front end: widths and state encodings.
 Assumes nothing of its surroundings.
*/
package bwsfe_pkg;
    typedef enum logic [1:0] {BWSFE_W8 = 2'h0, BWSFE_W16 = 2'h1, BWSFE_W32 = 2'h2} bwsfe_width_t;
    typedef enum logic [3:0] {
        BWSFE_HUNT = 4'h1, BWSFE_PAIR = 4'h2, BWSFE_SYNC = 4'h4, BWSFE_RUN = 4'h8
    } bwsfe_link_st_t;
    typedef enum logic [1:0] {BWSFE_HDR = 2'h1, BWSFE_PAY = 2'h2} bwsfe_dec_st_t;
    typedef enum logic [5:0] {
        BWSFE_H_IDLE = 6'h01, BWSFE_H_PAD = 6'h02, BWSFE_H_DET = 6'h04,
        BWSFE_H_GAP = 6'h08, BWSFE_H_SYNC = 6'h10, BWSFE_H_DATA = 6'h20
    } bwsfe_host_st_t;
endpackage

/* test/bwsfe_link_sva.sv */
/*
 Checker on the link between master and device, and on the device's decode outputs.
 Assumes instantiation beside the link interface in the bench, on one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module bwsfe_link_sva (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic [31:0] data,
    input wire logic valid,
    input wire logic ready,
    input wire logic i_program_pulse,
    input wire logic i_jtag_reprogram_instr,
    input wire logic [1:0] o_width,
    input wire logic o_width_locked,
    input wire logic o_synced,
    input wire logic [31:0] o_pkt_data,
    input wire logic o_pkt_valid,
    input wire logic i_pkt_ready,
    input wire logic o_crc_clear_cmd,
    input wire logic o_internal_reprogram_cmd,
    input wire logic [31:0] o_crc
);
    logic bb_q;
    logic bb_d;
    logic take;
    logic pair;
    logic clr;
    logic [1:0] exp_w;
    assign take = valid && ready && !o_width_locked;
    assign pair = take && bb_q;
    assign bb_d = take ? (data[7:0] == 8'hbb) : bb_q;
    assign clr = i_program_pulse || i_jtag_reprogram_instr || o_internal_reprogram_cmd;
    assign exp_w = (data[7:0] == 8'h11) ? 2'h0 : ((data[7:0] == 8'h22) ? 2'h1 : 2'h2);
    // Remembers that the last accepted beat before lock carried the first pattern byte
    always_ff @(posedge i_mclk)
    begin
        if (i_reset || clr || o_width_locked)
            bb_q <= 1'b0;
        else
            bb_q <= bb_d;
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    sequence s_pair_ok;
        pair && (data[7:0] inside {8'h11, 8'h22, 8'h44});
    endsequence
    sequence s_pair_bad;
        pair && !(data[7:0] inside {8'h11, 8'h22, 8'h44});
    endsequence
    a_pair_lock: assert property (s_pair_ok |=> o_width_locked && o_width == $past(exp_w))
        else $error("width not locked to the detected pair");
    a_bad_pair: assert property (s_pair_bad |=> !o_width_locked)
        else $error("width locked on an invalid pair");
    a_width_held: assert property (o_width_locked && !clr |=> o_width_locked && $stable(o_width))
        else $error("width changed without a clearing event");
    a_sync_after_lock: assert property (!o_width_locked |-> !o_synced)
        else $error("sync found before width lock");
    a_sync_word_end: assert property ($rose(o_synced) |-> $past(valid && ready && data[7:0] == 8'h66))
        else $error("sync rose without the last sync beat");
    a_no_early_pkt: assert property (!o_synced |-> !o_pkt_valid)
        else $error("packet output before sync");
    a_ready_hunt: assert property (!o_synced |-> ready)
        else $error("link stalled before sync");
    a_pkt_hold: assert property (o_pkt_valid && !i_pkt_ready && !clr |=> o_pkt_valid && $stable(o_pkt_data))
        else $error("packet word dropped while stalled");
    a_hold_beat: assert property (valid && !ready |=> valid && $stable(data))
        else $error("master changed a beat before it was taken");
    a_crc_zero: assert property (o_crc_clear_cmd |-> o_crc == 32'h0)
        else $error("crc not zero on clear command");
endmodule // bwsfe_link_sva
`default_nettype wire

/* test/testbench.sv */
/*
 Bench: master and device joined on one link, and a second device fed beat by beat.
 Assumes the design files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import bwsfe_pkg::*;
    logic i_mclk = 1'b0;
    logic i_reset = 1'b1;
    logic start = 1'b0;
    logic [1:0] width = 2'h0;
    logic [31:0] word = 32'h0;
    logic word_valid = 1'b0;
    logic prog1 = 1'b0;
    logic jtag1 = 1'b0;
    logic prog2 = 1'b0;
    logic pkt_ready1 = 1'b1;
    logic jtag2 = 1'b0;
    logic serial2 = 1'b0;
    logic [31:0] data2 = 32'h0;
    logic valid2 = 1'b0;
    logic word_ready, busy, lock1, sync1, pvalid1, crcclr1, iprog1, lock2, sync2, fdone2, partial2;
    logic [1:0] w1, w2;
    logic [4:0] preg1;
    logic [31:0] pdata1, timer1, wbs1, far1, crc1;
    int error_cnt = 0;
    int n_compared = 0;
    int cycles = 0;
    int crc_cnt = 0;
    int internal_reprogram_cmd_cnt = 0;
    int frame_cnt = 0;
    logic stall_seen = 1'b0;
    bwsfe_link_if link ();
    bwsfe_link_if link2 ();
    assign link2.data = data2;
    assign link2.valid = valid2;
    always #5 i_mclk = ~i_mclk;
    bwsfe_host i_bwsfe_host (.i_mclk(i_mclk), .i_reset(i_reset), .i_start(start), .i_width(width),
        .i_word(word), .i_word_valid(word_valid), .o_word_ready(word_ready), .o_busy(busy), .link(link));
    bwsfe_dev #(.INTERNAL_REPROGRAM_CMD_CODE(5'h0f)) i_bwsfe_dev (.i_mclk(i_mclk), .i_reset(i_reset), .i_program_pulse(prog1),
        .i_jtag_reprogram_instr(jtag1), .i_serial_mode(1'b0), .link(link), .o_width(w1), .o_width_locked(lock1),
        .o_synced(sync1), .o_pkt_data(pdata1), .o_pkt_reg(preg1), .o_pkt_valid(pvalid1), .i_pkt_ready(pkt_ready1),
        .o_timer(timer1), .o_warm_boot_start_addr(wbs1), .o_frame_address_reg(far1), .o_crc_clear_cmd(crcclr1),
        .o_internal_reprogram_cmd(iprog1), .o_crc(crc1), .o_frame_done(), .o_partial_frame());
    bwsfe_dev #(.FRAME_WORDS(2)) i_bwsfe_dev_2 (.i_mclk(i_mclk), .i_reset(i_reset), .i_program_pulse(prog2),
        .i_jtag_reprogram_instr(jtag2), .i_serial_mode(serial2), .link(link2), .o_width(w2),
        .o_width_locked(lock2), .o_synced(sync2), .o_pkt_data(), .o_pkt_reg(), .o_pkt_valid(),
        .i_pkt_ready(1'b1), .o_timer(), .o_warm_boot_start_addr(), .o_frame_address_reg(),
        .o_crc_clear_cmd(), .o_internal_reprogram_cmd(), .o_crc(), .o_frame_done(fdone2),
        .o_partial_frame(partial2));
    bwsfe_link_sva i_bwsfe_link_sva (.i_mclk(i_mclk), .i_reset(i_reset), .data(link.data), .valid(link.valid),
        .ready(link.ready), .i_program_pulse(prog1), .i_jtag_reprogram_instr(jtag1), .o_width(w1),
        .o_width_locked(lock1), .o_synced(sync1), .o_pkt_data(pdata1), .o_pkt_valid(pvalid1),
        .i_pkt_ready(pkt_ready1), .o_crc_clear_cmd(crcclr1), .o_internal_reprogram_cmd(iprog1), .o_crc(crc1));
    // Pulses are counted and a stall is flagged at the falling edge, where everything has settled
    always @(negedge i_mclk)
    begin
        if (crcclr1 === 1'b1) crc_cnt++;
        if (iprog1 === 1'b1) internal_reprogram_cmd_cnt++;
        if (fdone2 === 1'b1) frame_cnt++;
        if (link.valid === 1'b1 && link.ready === 1'b0) stall_seen = 1'b1;
    end
    always @(posedge i_mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("errors %0d compared %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    task automatic put_word(input logic [31:0] w);
        int i;
        word = w;
        word_valid = 1'b1;
        for (i = 0; i < 300 && word_ready !== 1'b1; i++) tick(1);
        tick(1);
        word_valid = 1'b0;
        tick(1);
    endtask
    task automatic expect_pkt(input logic [4:0] r, input logic [31:0] d);
        int i;
        for (i = 0; i < 300 && pvalid1 !== 1'b1; i++) tick(1);
        check("pkt_reg", {27'h0, preg1}, {27'h0, r});
        check("pkt_data", pdata1, d);
        tick(1);
    endtask
    task automatic reg_write(input logic [31:0] hdr, input logic [31:0] d, input logic [4:0] r);
        put_word(hdr);
        put_word(d);
        expect_pkt(r, d);
    endtask
    task automatic t_stream(input logic [1:0] w);
        int i;
        int c0;
        i_reset = 1'b1;
        tick(20);
        i_reset = 1'b0;
        width = w;
        start = 1'b1;
        tick(1);
        start = 1'b0;
        for (i = 0; i < 3000 && sync1 !== 1'b1; i++) tick(1);
        check("width", {30'h0, w1}, {30'h0, w});
        check("synced", {31'h0, sync1}, 32'h1);
        put_word(32'h20000000);
        reg_write(32'h30022001, 32'h5a0000a5 ^ {30'h0, w}, 5'h11);
        check("timer", timer1, 32'h5a0000a5 ^ {30'h0, w});
        reg_write(32'h30020001, 32'h00c0ffee, 5'h10);
        check("warm_boot", wbs1, 32'h00c0ffee);
        reg_write(32'h30002001, 32'h00000123, 5'h01);
        check("frame_addr", far1, 32'h00000123);
        c0 = crc_cnt;
        reg_write(32'h30008001, 32'h00000000, 5'h04);
        tick(3);
        check("null_cmd", crc_cnt, c0);
        reg_write(32'h30008001, 32'h00000007, 5'h04);
        tick(3);
        check("crc_clear", crc_cnt, c0 + 1);
        check("crc_zero", crc1, 32'h0);
    endtask
    task automatic t_stall();
        int i;
        pkt_ready1 = 1'b0;
        stall_seen = 1'b0;
        put_word(32'h30022004);
        for (i = 1; i <= 4; i++) put_word(32'h100 + i);
        tick(40);
        check("stall_hold", pdata1, 32'h101);
        check("stall_seen", {31'h0, stall_seen}, 32'h1);
        pkt_ready1 = 1'b1;
        for (i = 1; i <= 4; i++) expect_pkt(5'h11, 32'h100 + i);
    endtask
    task automatic t_clears();
        int p0;
        prog1 = 1'b1;
        tick(1);
        prog1 = 1'b0;
        tick(2);
        check("prog_unlock", {31'h0, lock1}, 32'h0);
        t_stream(2'h2);
        t_stall();
        p0 = internal_reprogram_cmd_cnt;
        put_word(32'h30008001);
        put_word(32'h0000000f);
        tick(10);
        check("internal_reprogram_cmd", internal_reprogram_cmd_cnt, p0 + 1);
        check("internal_reprogram_cmd_unlock", {31'h0, lock1}, 32'h0);
    endtask
    task automatic beat(input logic [31:0] d);
        int i;
        data2 = d;
        valid2 = 1'b1;
        for (i = 0; i < 50 && link2.ready !== 1'b1; i++) tick(1);
        tick(1);
    endtask
    task automatic clear2();
        valid2 = 1'b0;
        data2 = ~data2;
        jtag2 = 1'b1;
        tick(1);
        jtag2 = 1'b0;
        tick(1);
    endtask
    task automatic t_dev2();
        int f0;
        clear2();
        beat(32'hffffffff);
        beat(32'h5a5a5abb);
        beat(32'h00000033);
        beat(32'h000000bb);
        beat(32'h000000bb);
        check("bad_pair", {31'h0, lock2}, 32'h0);
        beat(32'h000000bb);
        beat(32'h11220044);
        tick(1);
        check("relock", {29'h0, lock2, w2}, 32'h6);
        check("presync", {31'h0, sync2}, 32'h0);
        beat(32'hffffffff);
        beat(32'haa995566);
        f0 = frame_cnt;
        beat(32'h30004002);
        beat(32'h1);
        beat(32'h2);
        beat(32'h30004000);
        beat(32'h50000001);
        beat(32'h3);
        valid2 = 1'b0;
        tick(6);
        check("frame_done", frame_cnt, f0 + 1);
        check("partial", {31'h0, partial2}, 32'h1);
        prog2 = 1'b1;
        tick(1);
        prog2 = 1'b0;
        check("partial_clear", {31'h0, partial2}, 32'h0);
        serial2 = 1'b1;
        clear2();
        beat(32'h000000bb);
        beat(32'h00000011);
        beat(32'haa995566);
        check("serial_sync", {29'h0, sync2, w2}, 32'h6);
        clear2();
        serial2 = 1'b0;
    endtask
    initial
    begin
        t_stream(2'h0);
        jtag1 = 1'b1;
        tick(1);
        jtag1 = 1'b0;
        tick(2);
        check("jtag_unlock", {31'h0, lock1}, 32'h0);
        t_stream(2'h1);
        t_clears();
        t_dev2();
        end_sim();
    end
endmodule // testbench
`default_nettype wire
